// ===== pkg/ufam_pkg.sv
// Constants shared by the serial port with frame check and address match.
// Assumes an 8-bit register space reached through a plain strobe port.
package ufam_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] SCON_OFS  = 8'h98;
  localparam logic [7:0] DATA_OFS  = 8'h99;
  localparam logic [7:0] BAUD_OFS  = 8'h9A;
  localparam logic [7:0] PCTL_OFS  = 8'h87;
  localparam logic [7:0] SLAVE_ADDRESS_REGISTER_OFS = 8'hA9;
  localparam logic [7:0] SMASK_OFS = 8'hB9;

  // Reset values.
  localparam logic [7:0] SCON_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h00;
  localparam logic [7:0] PCTL_RST  = 8'h00;
  localparam logic [7:0] SLAVE_ADDRESS_REGISTER_RST = 8'h00;
  localparam logic [7:0] SMASK_RST = 8'h00;

  // Bit positions in the serial control register.
  localparam int SC_MODE0_B = 7;
  localparam int SC_MODE1_B = 6;
  localparam int SC_MPE_B   = 5;
  localparam int SC_REN_B   = 4;
  localparam int SC_TB8_B   = 3;
  localparam int SC_RB8_B   = 2;
  localparam int SC_TI_B    = 1;
  localparam int SC_RI_B    = 0;

  // Bit positions in the power control register.
  localparam int PC_DBL_B  = 7;
  localparam int PC_FSEL_B = 6;

  // Operating modes selected by the two mode bits.
  typedef enum logic [1:0] {
    UFAM_SHIFT = 2'b00,
    UFAM_8VAR  = 2'b01,
    UFAM_9FIX  = 2'b10,
    UFAM_9VAR  = 2'b11
  } ufam_mode_t;

  // Timing counts, in system clocks, sixteenth-bit ticks or bits.
  localparam logic [7:0] M0_DIV      = 8'h05;
  localparam logic [7:0] M0_HALF     = 8'h03;
  localparam logic [7:0] M2_DIV_SLOW = 8'h01;
  localparam logic [7:0] M2_DIV_FAST = 8'h00;
  localparam logic [3:0] MID_SUB     = 4'h7;
  localparam logic [3:0] LAST_SUB    = 4'hF;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;
  localparam logic [3:0] RX8_LAST    = 4'h7;
  localparam logic [3:0] RX9_LAST    = 4'h8;
  localparam logic [3:0] TX8_STOP    = 4'h9;
  localparam logic [3:0] TX9_STOP    = 4'hA;

endpackage : ufam_pkg

// ===== tb/ufam_core_bench.sv
// Self-checking bench for ufam_core with a far serial node on the line.
// Assumes the rate divisor stays at its reset value, so UART bits last 16 clocks, or 32 in mode 2 without doubling.
`timescale 1ns/1ps
module ufam_core_bench import ufam_pkg::*; ;
  // Entry: control value, byte, then ninth bit, stop bit and expected receive flag.
  localparam logic [23:0] TBL [10] = '{24'hF0C207, 24'hF0C106, 24'hF0FF07, 24'hF0C002, 24'hB0C007,
                                       24'h70C003, 24'h70C000, 24'h701102, 24'h501103, 24'h401102};
  logic       sys_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic [7:0] addr        = 8'h00;
  logic [7:0] wdata       = 8'h00;
  logic       wr_stb      = 1'b0;
  logic       rd_stb      = 1'b0;
  logic [7:0] rdata;
  logic       txd;
  logic       rxd_out;
  logic       rxd_oe;
  logic       rxd_node;
  int         err_count   = 0;
  int         check_count = 0;
  // The shared data pin follows whoever enables its driver.
  wire        rxd_line    = rxd_oe ? rxd_out : rxd_node;

  always #12.5 sys_clk = ~sys_clk;

  ufam_core dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
                   .RDATA(rdata), .TXD(txd), .RXD_IN(rxd_line), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe));
  ufam_node node_u (.clk(sys_clk), .txd(txd), .rxd(rxd_node));

  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 cmp(exp & msk, rdata & msk);
  endtask : rdc

  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // Shift mode sends eight bits with one shift clock rise every six clocks.
  task automatic t_shift();
    logic [7:0] b;
    time        t0;
    time        t1;
    reg_wr(SCON_OFS, 8'h00);
    fork
      reg_wr(DATA_OFS, 8'h96);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd);
        t0 = t1;
        t1 = $time;
        b[i] = rxd_out;
      end
    join
    cmp(8'h96, b);
    cmp(8'h06, 8'((t1 - t0) / 25));
    repeat (12) @(posedge sys_clk);
    // shift receive unqualified.
    // With the enable bit set, eight shift clocks must still raise the flag and load the idle-high line.
    reg_wr(SCON_OFS, 8'h30);
    repeat (60) @(posedge sys_clk);
    rdc(SCON_OFS, 8'h01, 8'h01);
    rdc(DATA_OFS, 8'hFF, 8'hFF);
  endtask : t_shift

  // The transmit flag must still be clear early in the frame and set by mid stop bit.
  task automatic t_tx(input logic [7:0] sc, input logic [7:0] d, input int bt);
    logic [7:0] b;
    logic       n9;
    logic       stp;
    reg_wr(SCON_OFS, sc);
    fork
      node_u.recv(b, n9, stp, sc[7], bt);
      begin
        reg_wr(DATA_OFS, d);
        rdc(SCON_OFS, 8'h00, 8'h02);
      end
    join
    cmp(d, b);
    cmp({7'h00, sc[7] & sc[3]}, {7'h00, n9});
    cmp(8'h01, {7'h00, stp});
    rdc(SCON_OFS, 8'h02, 8'h02);
    // A data write during the stop bit is dropped, so the frame is let run out before the next call.
    repeat (bt) @(posedge sys_clk);
  endtask : t_tx

  // A missing stop bit sets the flag; a good frame and a write of 1 leave it set.
  task automatic t_fe();
    // Mode bit zero is only writable while framing select is 0, so mode 1 is set first.
    reg_wr(SCON_OFS, 8'h50);
    reg_wr(PCTL_OFS, 8'h40);
    node_u.send(8'h5A, 1'b0, 1'b0, 1'b0, 16);
    repeat (4) @(posedge sys_clk);
    rdc(SCON_OFS, 8'h80, 8'h80);
    reg_wr(SCON_OFS, 8'hD0);
    node_u.send(8'h33, 1'b0, 1'b0, 1'b1, 16);
    repeat (4) @(posedge sys_clk);
    rdc(SCON_OFS, 8'h81, 8'h81);
    rdc(DATA_OFS, 8'h33, 8'hFF);
    rdc(SCON_OFS, 8'h80, 8'h80);
    reg_wr(SCON_OFS, 8'h50);
    rdc(SCON_OFS, 8'h00, 8'h80);
    reg_wr(PCTL_OFS, 8'h00);
  endtask : t_fe

  // Given and broadcast matches, data frames, bad stop, comparison off and receiver off.
  task automatic t_addr();
    logic [23:0] e;
    reg_wr(SLAVE_ADDRESS_REGISTER_OFS, 8'hC0);
    reg_wr(SMASK_OFS, 8'hFD);
    rdc(SLAVE_ADDRESS_REGISTER_OFS, 8'hC0, 8'hFF);
    rdc(SMASK_OFS, 8'hFD, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      e = TBL[i];
      reg_wr(SCON_OFS, e[23:16]);
      node_u.send(e[15:8], e[2], e[23], e[1], (e[23:22] == 2'b10) ? 32 : 16);
      repeat (4) @(posedge sys_clk);
      rdc(SCON_OFS, {7'h00, e[0]}, 8'h01);
      if (e[0]) begin
        rdc(DATA_OFS, e[15:8], 8'hFF);
        rdc(SCON_OFS, {5'h00, e[23] ? e[2] : e[1], 2'h1}, 8'h05);
      end
    end
  endtask : t_addr

  // Reset is held for eight clocks, then the scenarios run in turn.
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(SCON_OFS, 8'h00, 8'hFF);
    rdc(SLAVE_ADDRESS_REGISTER_OFS, 8'h00, 8'hFF);
    rdc(SMASK_OFS, 8'h00, 8'hFF);
    reg_wr(8'h00, 8'h5A);
    rdc(8'h00, 8'h00, 8'hFF);
    t_shift();
    t_tx(8'h40, 8'hA5, 16);
    t_tx(8'hC8, 8'h3C, 16);
    t_tx(8'h80, 8'h5A, 32);
    reg_wr(PCTL_OFS, 8'h80);
    t_tx(8'h80, 8'hC3, 16);
    t_fe();
    t_addr();
    results();
  end

  // Watchdog sized well past the longest run of frames.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results();
  end
endmodule : ufam_core_bench

// ===== tb/ufam_core_chk.sv
// Port checker for ufam_core, attached by bind.
// Assumes software keeps to the strobe port rules.
`timescale 1ns/1ps
module ufam_core_chk import ufam_pkg::*; (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       TXD,
  input wire logic       RXD_IN,
  input wire logic       RXD_OUT,
  input wire logic       RXD_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  logic [1:0] mode_r;
  logic       fsel_r;
  logic       scw_r;
  logic       scrd_r;
  logic [1:0] fl_r;
  logic       fe_r;
  logic [7:0] sad_r;
  logic [7:0] msk_r;

  // Strobe decode of the offsets the checker mirrors.
  wire w_sc   = WR && ADDR == SCON_OFS;
  wire r_sc   = RD && ADDR == SCON_OFS;
  wire w_pc   = WR && ADDR == PCTL_OFS;
  wire mapped = ADDR inside {SCON_OFS, DATA_OFS, BAUD_OFS, PCTL_OFS, SLAVE_ADDRESS_REGISTER_OFS, SMASK_OFS};

  // Shadow of software writes. A flag seen set is forgotten at any control write,
  // because that write may legally clear it.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= 2'h0;
      fsel_r <= 1'b0;
      scw_r  <= 1'b0;
      scrd_r <= 1'b0;
      fl_r   <= 2'h0;
      fe_r   <= 1'b0;
      sad_r  <= 8'h00;
      msk_r  <= 8'h00;
    end else begin
      scrd_r <= r_sc;
      scw_r  <= scw_r | w_sc;
      if (w_sc && !fsel_r) mode_r[1] <= WDATA[7];
      if (w_sc) mode_r[0] <= WDATA[6];
      if (w_pc) fsel_r <= WDATA[PC_FSEL_B];
      if (WR && ADDR == SLAVE_ADDRESS_REGISTER_OFS) sad_r <= WDATA;
      if (WR && ADDR == SMASK_OFS) msk_r <= WDATA;
      fl_r <= w_sc ? 2'h0 : (fl_r | (scrd_r ? RDATA[1:0] : 2'h0));
      fe_r <= (w_sc || w_pc) ? 1'b0 : (fe_r | (scrd_r && fsel_r && RDATA[7]));
    end
  end

  property p_rd_quiet;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_unmapped;
    RD && !mapped |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read not zero");
  property p_scon_rst;
    r_sc && !scw_r |=> RDATA == 8'h00;
  endproperty
  a_scon_rst: assert property (p_scon_rst) else $error("control not zero after reset");
  property p_sad_rd;
    RD && ADDR == SLAVE_ADDRESS_REGISTER_OFS |=> RDATA == sad_r;
  endproperty
  a_sad_rd: assert property (p_sad_rd) else $error("slave address readback wrong");
  property p_msk_rd;
    RD && ADDR == SMASK_OFS |=> RDATA == msk_r;
  endproperty
  a_msk_rd: assert property (p_msk_rd) else $error("mask readback wrong");
  property p_oe_shift;
    RXD_OE |-> mode_r == 2'b00;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("data pin driven outside shift mode");
  property p_flags;
    r_sc |=> (RDATA[1:0] & fl_r) == fl_r;
  endproperty
  a_flags: assert property (p_flags) else $error("flag dropped without a write");
  property p_fe;
    r_sc && fe_r |=> RDATA[7];
  endproperty
  a_fe: assert property (p_fe) else $error("framing flag dropped without a write");
endmodule : ufam_core_chk

bind ufam_core ufam_core_chk chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .TXD(TXD), .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT), .RXD_OE(RXD_OE));

// ===== tb/ufam_node.sv
// Far serial node: sends frames into the receiver and decodes the transmitter.
// Assumes the bench passes the bit time in system clocks.
`timescale 1ns/1ps
module ufam_node (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;

  // ninth marks address
  // Start, data LSB first, optional ninth bit, stop; the line idles high after.
  task automatic send(input logic [7:0] b, input logic n9, input logic nine, input logic stp, input int bt);
    logic [10:0] f;
    f = nine ? {stp, n9, b, 1'b0} : {1'b1, stp, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send

  // Each bit is taken at its middle, well away from the edges where it changes.
  task automatic recv(output logic [7:0] b, output logic n9, output logic stp, input logic nine, input int bt);
    @(negedge txd);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      b[i] = txd;
    end
    n9 = 1'b0;
    if (nine) begin
      repeat (bt) @(posedge clk);
      n9 = txd;
    end
    repeat (bt) @(posedge clk);
    stp = txd;
  endtask : recv
endmodule : ufam_node

// ===== verilog/ufam_core.sv
// Serial port with framing-error detection and hardware address recognition.
// Assumes a plain register port and a 40 MHz SYS_CLK standing in for the oscillator.
// Summary of operation
// - A received frame with a low stop bit sets the framing error flag.
// - Control bit 7 reads and writes the framing error flag when framing select is 1, else mode bit zero.
// - The framing error flag survives good frames and clears only by a software write of 0.
// - Address comparison acts only while the multiprocessor enable bit is set.
// - In the 9-bit modes with comparison on, the receive flag rises only for a given or broadcast address.
// - An address frame has its ninth bit at 1; a frame with ninth bit 0 is data, never an address.
// - In mode 1 with comparison on, the receive flag needs a valid stop bit and a given or broadcast address.
// - Outside shift mode the transmit flag sets at the start of the outgoing stop bit.
// - Outside shift mode the receive flag sets during the incoming stop bit, after address qualification.
// - All eight control bits are 0 after reset.
// - Shift mode ignores the multiprocessor enable bit and does no address qualification.
// - The given address matches every bit where the mask is 1 against the slave address.
// - The broadcast address is slave address OR mask, and its zero bits are don't-care.
// - Slave address and mask reset to 0, so every byte matches.
`timescale 1ns/1ps
module ufam_core import ufam_pkg::*; (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  output logic            TXD,
  input  wire logic       RXD_IN,
  output logic            RXD_OUT,
  output logic            RXD_OE
);

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_STOP   = 5'b01000,
    RX_SHIFT0 = 5'b10000
  } ufam_rx_t;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b001,
    TX_BITS   = 3'b010,
    TX_SHIFT0 = 3'b100
  } ufam_tx_t;

  // Control and configuration registers.
  logic       sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
  logic       sm0_nxt, fe_nxt, ti_nxt, ri_nxt, rb8_nxt;
  logic       dbl_r, fsel_r;
  logic [7:0] slave_address_register_r, smask_r, baud_r, rxbuf_r, rdata_r;
  logic [7:0] rxbuf_nxt, rdata_nxt;

  // Receiver and transmitter state.
  ufam_rx_t   rx_st_r, rx_st_nxt;
  ufam_tx_t   tx_st_r, tx_st_nxt;
  logic [3:0] rx_sub_r, rx_sub_nxt, rx_cnt_r, rx_cnt_nxt;
  logic [3:0] tx_sub_r, tx_sub_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic       rxd_prev_r, txd_r, txd_nxt, rxo_r, rxoe_r;

  // Synchronised receive pin and tick sources.
  wire        rxd_s;
  wire        tick16;
  wire        tick_m0;
  wire [7:0]  m0_cnt;
  wire [7:0]  div16;

  ufam_sync #(.IDLE(1'b1)) u_rxd_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     (RXD_IN),
    .q     (rxd_s)
  );

  wire ufam_mode_t mode  = ufam_mode_t'({sm0_r, sm1_r});
  wire        is_shift   = (mode == UFAM_SHIFT);
  wire        is_nine    = sm0_r;
  assign div16 = (mode == UFAM_9FIX) ? (dbl_r ? M2_DIV_FAST : M2_DIV_SLOW) : baud_r;

  ufam_tick #(.W(8)) u_tick16 (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .clr   (1'b0),
    .div   (div16),
    .tick  (tick16),
    .cnt   ()
  );

  // The shift-mode divider restarts at each transfer so the first bit is full length.
  wire m0_clr = (tx_st_r == TX_IDLE && rx_st_r == RX_IDLE) || tx_st_nxt == TX_IDLE && rx_st_nxt == RX_IDLE;

  ufam_tick #(.W(8)) u_tick_m0 (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .clr   (m0_clr),
    .div   (M0_DIV),
    .tick  (tick_m0),
    .cnt   (m0_cnt)
  );

  // Register port decode.
  wire hit_scon  = (ADDR == SCON_OFS);
  wire hit_data  = (ADDR == DATA_OFS);
  wire hit_baud  = (ADDR == BAUD_OFS);
  wire hit_pctl  = (ADDR == PCTL_OFS);
  wire hit_slave_address_register = (ADDR == SLAVE_ADDRESS_REGISTER_OFS);
  wire hit_smask = (ADDR == SMASK_OFS);
  wire wr_scon   = WR && hit_scon;
  wire wr_data   = WR && hit_data;

  // bit 7 shows the flag or the mode bit, per framing select.
  wire [7:0] scon_rd = {fsel_r ? fe_r : sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};

  // Read data register; unmapped addresses read as zero.
  assign rdata_nxt = !RD      ? 8'h00 :
                     hit_scon  ? scon_rd :
                     hit_data  ? rxbuf_r :
                     hit_baud  ? baud_r :
                     hit_pctl  ? {dbl_r, fsel_r, 6'h00} :
                     hit_slave_address_register ? slave_address_register_r :
                     hit_smask ? smask_r : 8'h00;

  // given address: masked bits must equal the slave address.
  // broadcast: every one of address OR mask must be 1 in the byte.
  wire [7:0] rx_byte = is_nine ? rx_sh_r[7:0] : rx_sh_r[8:1];
  wire [7:0] bcast   = slave_address_register_r | smask_r;
  wire       given_m = (((rx_byte ^ slave_address_register_r) & smask_r) == 8'h00);
  wire       bcast_m = (((~rx_byte) & bcast) == 8'h00);
  wire       addr_m  = given_m || bcast_m;

  // Stop-bit evaluation point in the UART modes.
  wire rx_end  = (rx_st_r == RX_STOP) && tick16 && (rx_sub_r == LAST_SUB);
  wire stop_ok = rxd_s;
  wire ninth   = rx_sh_r[8];

  // in 9-bit modes only a ninth bit of 1 can pass as an address.
  wire qual    = !mpe_r ? 1'b1 : (is_nine ? (ninth && addr_m) : (stop_ok && addr_m));
  wire ri_uart = rx_end && !ri_r && qual;

  // shift mode finishes with no qualification at all.
  wire rx0_end = (rx_st_r == RX_SHIFT0) && tick_m0 && (rx_cnt_r == M0_LAST_BIT);
  wire ri_set  = ri_uart || rx0_end;

  wire fe_set  = rx_end && !stop_ok;

  // flag at the edge that starts the stop bit.
  wire tx_shift = (tx_st_r == TX_BITS) && tick16 && (tx_sub_r == LAST_SUB);
  wire [3:0] tx_stop_ix = is_nine ? TX9_STOP : TX8_STOP;
  wire ti_uart = tx_shift && ((tx_cnt_r + 4'h1) == tx_stop_ix);
  wire tx0_end = (tx_st_r == TX_SHIFT0) && tick_m0 && (tx_cnt_r == M0_LAST_BIT);
  wire ti_set  = ti_uart || tx0_end;

  // Flag next values: a hardware set wins over a software clear.
  always_comb begin
    // mode bit zero writable only with framing select at 0.
    sm0_nxt = (wr_scon && !fsel_r) ? WDATA[SC_MODE0_B] : sm0_r;
    // flag clears only by a written 0 while it is visible.
    fe_nxt  = fe_set || (fe_r && !(wr_scon && fsel_r && !WDATA[SC_MODE0_B]));
    // flags hold until software writes them.
    ti_nxt  = ti_set || (wr_scon ? WDATA[SC_TI_B] : ti_r);
    ri_nxt  = ri_set || (wr_scon ? WDATA[SC_RI_B] : ri_r);
    // received ninth bit, or stop bit in mode 1.
    rb8_nxt   = ri_uart ? (is_nine ? ninth : stop_ok) : (wr_scon ? WDATA[SC_RB8_B] : rb8_r);
    rxbuf_nxt = ri_set ? (rx0_end ? {rxd_s, rx_sh_r[8:2]} : rx_byte) : rxbuf_r;
  end

  // Receiver sequencing.
  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_sub_nxt = rx_sub_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_sh_nxt  = rx_sh_r;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_sub_nxt = 4'h0;
        rx_cnt_nxt = 4'h0;
        if (ren_r && is_shift && !ri_r && tx_st_r == TX_IDLE) begin
          rx_st_nxt = RX_SHIFT0;
        end else if (ren_r && !is_shift && rxd_prev_r && !rxd_s) begin
          rx_st_nxt = RX_START;
        end
      end
      RX_START: begin
        if (tick16) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          // A start bit gone high at mid-bit is a glitch.
          if (rx_sub_r == MID_SUB) begin
            rx_sub_nxt = 4'h0;
            rx_st_nxt  = rxd_s ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick16) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == LAST_SUB) begin
            rx_sh_nxt  = {rxd_s, rx_sh_r[8:1]};
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            // stop bit follows 8 or 9 data bits.
            if (rx_cnt_r == (is_nine ? RX9_LAST : RX8_LAST)) rx_st_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick16) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == LAST_SUB) rx_st_nxt = RX_IDLE;
        end
      end
      RX_SHIFT0: begin
        if (tick_m0) begin
          rx_sh_nxt  = {rxd_s, rx_sh_r[8:1]};
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == M0_LAST_BIT) rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  // Transmitter sequencing; a data write while busy is dropped.
  always_comb begin
    tx_st_nxt  = tx_st_r;
    tx_sub_nxt = tx_sub_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_sh_nxt  = tx_sh_r;
    unique case (tx_st_r)
      TX_IDLE: begin
        tx_sub_nxt = 4'h0;
        tx_cnt_nxt = 4'h0;
        if (wr_data && is_shift && rx_st_r == RX_IDLE) begin
          tx_st_nxt = TX_SHIFT0;
          tx_sh_nxt = {3'h7, WDATA};
        end else if (wr_data && !is_shift) begin
          tx_st_nxt = TX_BITS;
          // ninth bit sits between data and stop.
          tx_sh_nxt = is_nine ? {1'b1, tb8_r, WDATA, 1'b0} : {2'h3, WDATA, 1'b0};
        end
      end
      TX_BITS: begin
        if (tick16) begin
          tx_sub_nxt = tx_sub_r + 4'h1;
          if (tx_sub_r == LAST_SUB) begin
            tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
            tx_cnt_nxt = tx_cnt_r + 4'h1;
            if (tx_cnt_r == tx_stop_ix) tx_st_nxt = TX_IDLE;
          end
        end
      end
      TX_SHIFT0: begin
        if (tick_m0) begin
          tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
          tx_cnt_nxt = tx_cnt_r + 4'h1;
          if (tx_cnt_r == M0_LAST_BIT) tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  // Shift mode drives a clock low for the first half of each bit on TXD.
  wire shift_busy = (tx_st_r == TX_SHIFT0) || (rx_st_r == RX_SHIFT0);
  assign txd_nxt  = shift_busy ? (m0_cnt >= M0_HALF) : ((tx_st_r == TX_BITS) ? tx_sh_r[0] : 1'b1);

  // reset values of all software registers.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= SCON_RST;
      fe_r    <= 1'b0;
      {dbl_r, fsel_r} <= PCTL_RST[7:6];
      slave_address_register_r <= SLAVE_ADDRESS_REGISTER_RST;
      smask_r <= SMASK_RST;
      baud_r  <= BAUD_RST;
      rxbuf_r <= DATA_RST;
      rdata_r <= 8'h00;
    end else begin
      sm0_r   <= sm0_nxt;
      fe_r    <= fe_nxt;
      ti_r    <= ti_nxt;
      ri_r    <= ri_nxt;
      rb8_r   <= rb8_nxt;
      rxbuf_r <= rxbuf_nxt;
      rdata_r <= rdata_nxt;
      if (wr_scon) begin
        sm1_r <= WDATA[SC_MODE1_B];
        mpe_r <= WDATA[SC_MPE_B];
        ren_r <= WDATA[SC_REN_B];
        tb8_r <= WDATA[SC_TB8_B];
      end
      if (WR && hit_pctl) {dbl_r, fsel_r} <= WDATA[PC_DBL_B:PC_FSEL_B];
      if (WR && hit_slave_address_register) slave_address_register_r <= WDATA;
      if (WR && hit_smask) smask_r <= WDATA;
      if (WR && hit_baud) baud_r <= WDATA;
    end
  end

  // Shift engines and pin registers.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_st_r    <= RX_IDLE;
      tx_st_r    <= TX_IDLE;
      {rx_sub_r, rx_cnt_r, tx_sub_r, tx_cnt_r} <= 16'h0000;
      rx_sh_r    <= 9'h000;
      tx_sh_r    <= 11'h7FF;
      rxd_prev_r <= 1'b1;
      txd_r      <= 1'b1;
      rxo_r      <= 1'b1;
      rxoe_r     <= 1'b0;
    end else begin
      rx_st_r    <= rx_st_nxt;
      tx_st_r    <= tx_st_nxt;
      {rx_sub_r, rx_cnt_r, tx_sub_r, tx_cnt_r} <= {rx_sub_nxt, rx_cnt_nxt, tx_sub_nxt, tx_cnt_nxt};
      rx_sh_r    <= rx_sh_nxt;
      tx_sh_r    <= tx_sh_nxt;
      rxd_prev_r <= rxd_s;
      txd_r      <= txd_nxt;
      rxo_r      <= (tx_st_r == TX_SHIFT0) ? tx_sh_r[0] : 1'b1;
      rxoe_r     <= (tx_st_r == TX_SHIFT0);
    end
  end

  assign RDATA   = rdata_r;
  assign TXD     = txd_r;
  assign RXD_OUT = rxo_r;
  assign RXD_OE  = rxoe_r;

endmodule : ufam_core

// ===== verilog/ufam_sync.sv
// Two-flop synchroniser for a level arriving from a pin.
// Assumes the level is held far longer than two clocks.
`timescale 1ns/1ps
module ufam_sync import ufam_pkg::*; #(
  parameter logic IDLE = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic s1_r;
  logic s2_r;

  // Only the second stage is visible outside.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= IDLE;
      s2_r <= IDLE;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule : ufam_sync

// ===== verilog/ufam_tick.sv
// Free-running tick divider: one tick every DIV+1 clocks.
// Assumes DIV is static while a frame is in flight.
`timescale 1ns/1ps
module ufam_tick import ufam_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic [W-1:0] div,
  output logic              tick,
  output logic [W-1:0]      cnt
);

  initial begin
    if (W < 4) $error("ufam_tick: W must be at least 4");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Compare with >= so a shrinking divisor never strands the counter.
  assign tick    = (cnt_r >= div);
  assign cnt_nxt = (clr || tick) ? '0 : cnt_r + W'(1);
  assign cnt     = cnt_r;

  // Counter register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= '0;
    else        cnt_r <= cnt_nxt;
  end

endmodule : ufam_tick
